// *** shared/sstp_defines.vh ***
// Constants for the scanner status telegram packer.
// Function
// - A 32-bit scan counter sits in telegram bytes 8 to 11, counts each completed scan and clears only at power-up.
// - Byte 12 bit 7 is 1 while function A is configured and active.
// - Byte 12 bit 6 shows the active warning field of function A, 0 violated and 1 free.
// - Byte 12 bit 5 shows the active protective field of function A, 0 violated and 1 free.
// - Bit 4 of bytes 12 and 16 is 1 while the restart interlock of function A or B is engaged.
// - Byte 12 bit 3 mirrors the internal safety switch output of function A.
// - Bytes 13 and 14 carry the bank and the first, second and third field pairs of function A, numbers 1 to 10.
// - Byte 15 bits 7 and 6 show warning segments 1 and 2 of function A, 0 violated and 1 free.
// - Byte 15 bits 5 and 4 show protective segments 1 and 2 of function A, 0 violated and 1 free.
// - Bits 3 and 2 of bytes 15 and 19 are 1 when the matching defined field pair is selected.
// - Bytes 16 to 19 carry function B status in the same layout as bytes 12 to 15.
// - All function status bits and selection fields read zero until the scanner first updates them.
// - Byte 0 holds the status profile variant, which is 1.
`ifndef SSTP_DEFINES_VH
`define SSTP_DEFINES_VH

// ----------------------------------------
// Telegram layout
// ----------------------------------------
`define SSTP_TEL_LEN        5'h14
`define SSTP_TEL_LAST       5'h13
`define SSTP_BYTE_VARIANT   5'h00
`define SSTP_BYTE_CNT0      5'h08
`define SSTP_BYTE_CNT1      5'h09
`define SSTP_BYTE_CNT2      5'h0a
`define SSTP_BYTE_CNT3      5'h0b
`define SSTP_BYTE_FA0       5'h0c
`define SSTP_BYTE_FA1       5'h0d
`define SSTP_BYTE_FA2       5'h0e
`define SSTP_BYTE_FA3       5'h0f
`define SSTP_BYTE_FB0       5'h10
`define SSTP_BYTE_FB1       5'h11
`define SSTP_BYTE_FB2       5'h12
`define SSTP_BYTE_FB3       5'h13
`define SSTP_VARIANT        8'h01
`define SSTP_CNT_RST        32'h0000_0000
`define SSTP_FUNC_RST       32'h0000_0000

// ----------------------------------------
// Register map
// ----------------------------------------
`define SSTP_ADDR_CTRL      8'h00
`define SSTP_ADDR_STATUS    8'h04
`define SSTP_ADDR_MASK      8'h08
`define SSTP_ADDR_SCAN      8'h0c
`define SSTP_ADDR_STATE     8'h10
`define SSTP_ADDR_FUNC_A    8'h14
`define SSTP_ADDR_FUNC_B    8'h18
`define SSTP_CTRL_EN_BIT    0
`define SSTP_CTRL_FORCE_BIT 1
`define SSTP_CTRL_RST       1'h1
`define SSTP_EV_SCAN_BIT    0
`define SSTP_EV_SENT_BIT    1
`define SSTP_EV_SKIP_BIT    2
`define SSTP_EV_RST         3'h0
`define SSTP_MASK_RST       3'h0

`endif

// *** src/sstp_sync.v ***
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module sstp_sync
#(
  parameter WIDTH = 1
)
(
  // Clock and reset
  input  wire             clock_in,
  input  wire             rstn_in,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage, to contain metastability.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** src/sstp_frame_mem.v ***
// Small telegram buffer with registered read data.
`timescale 1ns/100ps
module sstp_frame_mem
#(
  parameter DW    = 8,
  parameter AW    = 5,
  parameter DEPTH = 32
)
(
  // Clock and reset
  input  wire          clock_in,
  input  wire          rstn_in,
  // Write side
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  // Read side
  input  wire          rd_en_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);

  reg [DW-1:0] mem_r [0:DEPTH-1];

  // The array has no reset so that it maps onto plain RAM cells.
  always @(posedge clock_in)
  begin
    if (wr_en_in)
      mem_r[wr_addr_in] <= wr_data_in;
  end

  // Read data come out of a register one cycle after the request.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rd_data_out <= {DW{1'b0}};
    else if (rd_en_in)
      rd_data_out <= mem_r[rd_addr_in];
  end

endmodule

// *** src/sstp_packer.v ***
// Status telegram packer: builds bytes 0 to 19 and sends them byte by byte.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "sstp_defines.vh"
module sstp_packer
(
  // Clock and reset
  input  wire        clock_in,
  input  wire        rstn_in,
  // Scanner core events
  input  wire        scan_done_in,
  input  wire        status_load_in,
  // Function A status
  input  wire        func_a_active_in,
  input  wire        func_a_warn_field_free_in,
  input  wire        func_a_prot_field_free_in,
  input  wire        func_a_restart_interlock_in,
  input  wire        func_a_safety_switch_output_in,
  input  wire [3:0]  func_a_bank_sel_in,
  input  wire [3:0]  func_a_pair_sel_one_in,
  input  wire [3:0]  func_a_pair_sel_two_in,
  input  wire [3:0]  func_a_pair_sel_three_in,
  input  wire        func_a_warn_segment_one_in,
  input  wire        func_a_warn_segment_two_in,
  input  wire        func_a_prot_segment_one_in,
  input  wire        func_a_prot_segment_two_in,
  input  wire        func_a_defined_pair_one_in,
  input  wire        func_a_defined_pair_two_in,
  // Function B status
  input  wire        func_b_active_in,
  input  wire        func_b_warn_field_free_in,
  input  wire        func_b_prot_field_free_in,
  input  wire        func_b_restart_interlock_in,
  input  wire        func_b_safety_switch_output_in,
  input  wire [3:0]  func_b_bank_sel_in,
  input  wire [3:0]  func_b_pair_sel_one_in,
  input  wire [3:0]  func_b_pair_sel_two_in,
  input  wire [3:0]  func_b_pair_sel_three_in,
  input  wire        func_b_warn_segment_one_in,
  input  wire        func_b_warn_segment_two_in,
  input  wire        func_b_prot_segment_one_in,
  input  wire        func_b_prot_segment_two_in,
  input  wire        func_b_defined_pair_one_in,
  input  wire        func_b_defined_pair_two_in,
  // Register port
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // Telegram byte stream to the diagnostics host
  input  wire        tx_ready_in,
  output reg         tx_valid_out,
  output reg  [7:0]  tx_data_out,
  output reg  [4:0]  tx_index_out,
  // Interrupt
  output reg         irq_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_LOAD  = 5'h02;
  localparam [4:0] ST_FETCH = 5'h04;
  localparam [4:0] ST_LATCH = 5'h08;
  localparam [4:0] ST_SEND  = 5'h10;

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Packs one protective function into its four telegram bytes, first byte on top.
  function [31:0] pack_func;
    input       act;
    input       wf;
    input       pf;
    input       res;
    input       sw;
    input [3:0] bank;
    input [3:0] p1;
    input [3:0] p2;
    input [3:0] p3;
    input       ws1;
    input       ws2;
    input       ps1;
    input       ps2;
    input       dp1;
    input       dp2;
    begin
      pack_func[31]    = act;
      pack_func[30]    = wf;
      pack_func[29]    = pf;
      pack_func[28]    = res;
      pack_func[27]    = sw;
      pack_func[26:24] = 3'h0;
      pack_func[23:8]  = {bank, p1, p2, p3};
      pack_func[7:6]   = {ws1, ws2};
      pack_func[5:4]   = {ps1, ps2};
      pack_func[3:2]   = {dp1, dp2};
      pack_func[1:0]   = 2'h0;
    end
  endfunction

  // Picks the telegram byte at a given index.
  function [7:0] tel_byte;
    input [4:0]  idx;
    input [31:0] cnt;
    input [31:0] fa;
    input [31:0] fb;
    begin
      case (idx)
        `SSTP_BYTE_VARIANT: tel_byte = `SSTP_VARIANT;
        `SSTP_BYTE_CNT0:    tel_byte = cnt[7:0];
        `SSTP_BYTE_CNT1:    tel_byte = cnt[15:8];
        `SSTP_BYTE_CNT2:    tel_byte = cnt[23:16];
        `SSTP_BYTE_CNT3:    tel_byte = cnt[31:24];
        `SSTP_BYTE_FA0:     tel_byte = fa[31:24];
        `SSTP_BYTE_FA1:     tel_byte = fa[23:16];
        `SSTP_BYTE_FA2:     tel_byte = fa[15:8];
        `SSTP_BYTE_FA3:     tel_byte = fa[7:0];
        `SSTP_BYTE_FB0:     tel_byte = fb[31:24];
        `SSTP_BYTE_FB1:     tel_byte = fb[23:16];
        `SSTP_BYTE_FB2:     tel_byte = fb[15:8];
        `SSTP_BYTE_FB3:     tel_byte = fb[7:0];
        default:            tel_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [31:0] cnt_r;
  reg  [31:0] snap_r;
  reg  [31:0] fa_r;
  reg  [31:0] fb_r;
  reg  [4:0]  state_r;
  reg  [4:0]  state_nxt;
  reg  [4:0]  idx_r;
  reg  [4:0]  idx_nxt;
  reg         en_r;
  reg         force_r;
  reg  [2:0]  sts_r;
  reg  [2:0]  mask_r;
  reg  [2:0]  sts_nxt;
  reg         mem_wr;
  reg         mem_rd;
  reg         sent_ev;
  wire [31:0] cnt_nxt;
  wire        ready_s;
  wire        idle;
  wire        start_req;
  wire        start;
  wire        skip_ev;
  wire [7:0]  mem_rdata;
  wire [2:0]  ev;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------

  // The host's ready comes from another board, so it is synchronised first.
  sstp_sync #(.WIDTH(1)) u_ready_sync
  (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in (tx_ready_in),
    .sync_out (ready_s)
  );

  // A frozen copy of one telegram, so a new scan cannot tear a frame in flight.
  sstp_frame_mem #(.DW(8), .AW(5), .DEPTH(32)) u_frame_mem
  (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (mem_wr),
    .wr_addr_in  (idx_r),
    .wr_data_in  (tel_byte(idx_r, snap_r, fa_r, fb_r)),
    .rd_en_in    (mem_rd),
    .rd_addr_in  (idx_r),
    .rd_data_out (mem_rdata)
  );

  // ----------------------------------------
  // Scan counter and status latches
  // ----------------------------------------

  // The counter wraps at the top; only the power-up reset brings it to zero.
  assign cnt_nxt = cnt_r + {{31{1'b0}}, scan_done_in};

  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_r <= `SSTP_CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end

  // Status stays zero until the core strobes its first update.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fa_r <= `SSTP_FUNC_RST;
      fb_r <= `SSTP_FUNC_RST;
    end
    else if (status_load_in)
    begin
      fa_r <= pack_func(func_a_active_in, func_a_warn_field_free_in, func_a_prot_field_free_in,
                        func_a_restart_interlock_in, func_a_safety_switch_output_in,
                        func_a_bank_sel_in, func_a_pair_sel_one_in, func_a_pair_sel_two_in,
                        func_a_pair_sel_three_in, func_a_warn_segment_one_in,
                        func_a_warn_segment_two_in, func_a_prot_segment_one_in,
                        func_a_prot_segment_two_in, func_a_defined_pair_one_in,
                        func_a_defined_pair_two_in);
      fb_r <= pack_func(func_b_active_in, func_b_warn_field_free_in, func_b_prot_field_free_in,
                        func_b_restart_interlock_in, func_b_safety_switch_output_in,
                        func_b_bank_sel_in, func_b_pair_sel_one_in, func_b_pair_sel_two_in,
                        func_b_pair_sel_three_in, func_b_warn_segment_one_in,
                        func_b_warn_segment_two_in, func_b_prot_segment_one_in,
                        func_b_prot_segment_two_in, func_b_defined_pair_one_in,
                        func_b_defined_pair_two_in);
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------

  // A frame starts on a scan or a software request, only while the sender is idle.
  assign idle      = (state_r == ST_IDLE);
  assign start_req = en_r & (scan_done_in | force_r);
  assign start     = start_req & idle;
  // A scan that finds the sender busy gets no telegram of its own.
  assign skip_ev   = en_r & scan_done_in & ~idle;

  // Next state: load twenty bytes, then fetch, present and hand over each one.
  always @*
  begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    sent_ev   = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        idx_nxt = 5'h00;
        if (start)
          state_nxt = ST_LOAD;
      end
      ST_LOAD:
      begin
        mem_wr = 1'b1;
        if (idx_r == `SSTP_TEL_LAST)
        begin
          idx_nxt   = 5'h00;
          state_nxt = ST_FETCH;
        end
        else
          idx_nxt = idx_r + 5'h01;
      end
      ST_FETCH:
      begin
        mem_rd    = 1'b1;
        state_nxt = ST_LATCH;
      end
      ST_LATCH:
        state_nxt = ST_SEND;
      ST_SEND:
      begin
        if (ready_s)
        begin
          if (idx_r == `SSTP_TEL_LAST)
          begin
            sent_ev   = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
          begin
            idx_nxt   = idx_r + 5'h01;
            state_nxt = ST_FETCH;
          end
        end
      end
      default:
      begin
        idx_nxt   = 5'h00;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; the counter is frozen here so all four bytes agree.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= ST_IDLE;
      idx_r   <= 5'h00;
      snap_r  <= `SSTP_CNT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      if (start)
        snap_r <= cnt_nxt;
    end
  end

  // Byte stream outputs; valid stays up until the synchronised ready is seen.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
      tx_index_out <= 5'h00;
    end
    else if (state_r == ST_LATCH)
    begin
      tx_valid_out <= 1'b1;
      tx_data_out  <= mem_rdata;
      tx_index_out <= idx_r;
    end
    else if ((state_r == ST_SEND) && ready_s)
      tx_valid_out <= 1'b0;
  end

  // ----------------------------------------
  // Control, status and interrupt
  // ----------------------------------------

  assign ev = {skip_ev, sent_ev, scan_done_in};

  // A new event beats a write-one-to-clear in the same cycle.
  always @*
  begin
    sts_nxt = sts_r;
    if (reg_wr_in && (reg_addr_in == `SSTP_ADDR_STATUS))
      sts_nxt = sts_r & ~reg_wdata_in[2:0];
    sts_nxt = sts_nxt | ev;
  end

  // Force is a pending request that waits for the sender to go idle.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      en_r    <= `SSTP_CTRL_RST;
      force_r <= 1'b0;
      mask_r  <= `SSTP_MASK_RST;
      sts_r   <= `SSTP_EV_RST;
      irq_out <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == `SSTP_ADDR_CTRL))
        en_r <= reg_wdata_in[`SSTP_CTRL_EN_BIT];
      if (start)
        force_r <= 1'b0;
      else if (reg_wr_in && (reg_addr_in == `SSTP_ADDR_CTRL) && reg_wdata_in[`SSTP_CTRL_FORCE_BIT])
        force_r <= 1'b1;
      if (reg_wr_in && (reg_addr_in == `SSTP_ADDR_MASK))
        mask_r <= reg_wdata_in[2:0];
      sts_r   <= sts_nxt;
      irq_out <= |(sts_nxt & mask_r);
    end
  end

  // Read data appear one cycle after the strobe; unmapped addresses read zero.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `SSTP_ADDR_CTRL:   reg_rdata_out <= {30'h0000_0000, force_r, en_r};
        `SSTP_ADDR_STATUS: reg_rdata_out <= {29'h0000_0000, sts_r};
        `SSTP_ADDR_MASK:   reg_rdata_out <= {29'h0000_0000, mask_r};
        `SSTP_ADDR_SCAN:   reg_rdata_out <= cnt_r;
        `SSTP_ADDR_STATE:  reg_rdata_out <= {19'h0_0000, state_r, 3'h0, idx_r};
        `SSTP_ADDR_FUNC_A: reg_rdata_out <= fa_r;
        `SSTP_ADDR_FUNC_B: reg_rdata_out <= fb_r;
        default:           reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// *** verification/sstp_packer_monitor.sv ***
// Checker for the status telegram byte stream of the packer.
`timescale 1ns/100ps
module sstp_packer_monitor
(
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       rstn_in,
  // Telegram stream
  input wire logic       tx_ready_in,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [4:0] tx_index_out
);
  logic [4:0] prev_idx_r;

  // Last offered index, so that each new offer can be tied to the one before.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      prev_idx_r <= 5'h1f;
    else if (tx_valid_out)
      prev_idx_r <= tx_index_out;
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  variant_byte_a: assert property (tx_valid_out && tx_index_out == 5'h00 |-> tx_data_out == 8'h01)
    else $error("variant byte wrong");
  spare_byte_a: assert property (tx_valid_out && tx_index_out == 5'h07 |-> tx_data_out == 8'h00)
    else $error("byte 7 not zero");
  flag_spare_a: assert property (tx_valid_out && (tx_index_out == 5'h0c || tx_index_out == 5'h10)
    |-> tx_data_out[2:0] == 3'h0)
    else $error("spare flag bits not zero");
  seg_spare_a: assert property (tx_valid_out && (tx_index_out == 5'h0f || tx_index_out == 5'h13)
    |-> tx_data_out[1:0] == 2'h0)
    else $error("spare segment bits not zero");
  byte_order_a: assert property ($rose(tx_valid_out)
    |-> tx_index_out == 5'h00 || tx_index_out == prev_idx_r + 5'h01)
    else $error("byte out of order");
  index_range_a: assert property (tx_valid_out |-> tx_index_out <= 5'h13)
    else $error("index beyond byte 19");
  offer_hold_a: assert property (tx_valid_out && $past(tx_valid_out)
    |-> $stable(tx_data_out) && $stable(tx_index_out))
    else $error("offer changed while standing");
  offer_gap_a: assert property ($fell(tx_valid_out) |=> !tx_valid_out)
    else $error("gap after byte too short");
  accept_bound_a: assert property (tx_valid_out && tx_ready_in |-> ##[1:4] !tx_valid_out)
    else $error("ready not taken in time");
endmodule

bind sstp_packer sstp_packer_monitor u_mon (.clock_in(clock_in), .rstn_in(rstn_in), .tx_ready_in(tx_ready_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_index_out(tx_index_out));

// *** verification/sstp_host_model.sv ***
// Diagnostics host model: takes the telegram bytes and keeps the last frame.
`timescale 1ns/100ps
module sstp_host_model
(
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // Answer delay in cycles
  input  wire logic [1:0]   stall_in,
  // Telegram stream
  input  wire logic         tx_valid_out,
  input  wire logic [7:0]   tx_data_out,
  input  wire logic [4:0]   tx_index_out,
  output logic              tx_ready_in,
  // Received frame
  output logic [159:0]      frame_out,
  output logic [31:0]       scan_out,
  output int                frame_count_out
);
  logic [1:0] st_r;
  logic [1:0] wait_r;
  logic [4:0] last_r;

  // Counter bytes arrive least significant first, so byte 8 is the low end.
  assign scan_out = frame_out[95:64];

  // Bytes are taken by index change, not by our own ready, because a late ready may still be seen high.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      last_r <= 5'h1f;
      frame_out <= '0;
      frame_count_out <= 0;
    end
    else if (tx_valid_out && tx_index_out != last_r)
    begin
      last_r <= tx_index_out;
      frame_out[tx_index_out*8 +: 8] <= tx_data_out;
      if (tx_index_out == 5'h13)
        frame_count_out <= frame_count_out + 1;
    end
  end

  // Ready rises some cycles after an offer and falls once the offer is withdrawn.
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= 2'h0;
      wait_r <= 2'h0;
      tx_ready_in <= 1'b0;
    end
    else if (st_r == 2'h0 && tx_valid_out)
    begin
      wait_r <= stall_in;
      st_r <= 2'h1;
    end
    else if (st_r == 2'h1)
    begin
      wait_r <= wait_r - 2'h1;
      tx_ready_in <= (wait_r == 2'h0);
      st_r <= (wait_r == 2'h0) ? 2'h2 : 2'h1;
    end
    else if (st_r == 2'h2 && !tx_valid_out)
    begin
      tx_ready_in <= 1'b0;
      st_r <= 2'h0;
    end
  end
endmodule

// *** verification/sstp_packer_bench.sv ***
// Self-checking bench for the status telegram packer.
`timescale 1ns/100ps
module sstp_packer_bench;
  logic         clock_in, rstn_in, scan_done_in, status_load_in, reg_wr_in, reg_rd_in;
  logic [7:0]   reg_addr_in;
  logic [31:0]  reg_wdata_in, fa_r, fb_r, fa_lat, fb_lat;
  logic [1:0]   stall_r;
  wire  [31:0]  reg_rdata_out, scan_seen;
  wire          tx_ready_in, tx_valid_out, irq_out;
  wire  [7:0]   tx_data_out;
  wire  [4:0]   tx_index_out;
  wire  [159:0] frame;
  int           frame_count, bad_count, tests_run, exp_cnt, seed, n;

  sstp_packer u_dut
  (
    .clock_in(clock_in), .rstn_in(rstn_in), .scan_done_in(scan_done_in), .status_load_in(status_load_in),
    .func_a_active_in(fa_r[31]), .func_a_warn_field_free_in(fa_r[30]), .func_a_prot_field_free_in(fa_r[29]),
    .func_a_restart_interlock_in(fa_r[28]), .func_a_safety_switch_output_in(fa_r[27]),
    .func_a_bank_sel_in(fa_r[23:20]), .func_a_pair_sel_one_in(fa_r[19:16]), .func_a_pair_sel_two_in(fa_r[15:12]),
    .func_a_pair_sel_three_in(fa_r[11:8]), .func_a_warn_segment_one_in(fa_r[7]), .func_a_warn_segment_two_in(fa_r[6]),
    .func_a_prot_segment_one_in(fa_r[5]), .func_a_prot_segment_two_in(fa_r[4]),
    .func_a_defined_pair_one_in(fa_r[3]), .func_a_defined_pair_two_in(fa_r[2]),
    .func_b_active_in(fb_r[31]), .func_b_warn_field_free_in(fb_r[30]), .func_b_prot_field_free_in(fb_r[29]),
    .func_b_restart_interlock_in(fb_r[28]), .func_b_safety_switch_output_in(fb_r[27]),
    .func_b_bank_sel_in(fb_r[23:20]), .func_b_pair_sel_one_in(fb_r[19:16]), .func_b_pair_sel_two_in(fb_r[15:12]),
    .func_b_pair_sel_three_in(fb_r[11:8]), .func_b_warn_segment_one_in(fb_r[7]), .func_b_warn_segment_two_in(fb_r[6]),
    .func_b_prot_segment_one_in(fb_r[5]), .func_b_prot_segment_two_in(fb_r[4]),
    .func_b_defined_pair_one_in(fb_r[3]), .func_b_defined_pair_two_in(fb_r[2]),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_index_out(tx_index_out), .irq_out(irq_out)
  );

  sstp_host_model u_host
  (
    .clock_in(clock_in), .rstn_in(rstn_in), .stall_in(stall_r), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_index_out(tx_index_out), .tx_ready_in(tx_ready_in),
    .frame_out(frame), .scan_out(scan_seen), .frame_count_out(frame_count)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bus cycles: strobes last one cycle, read data is taken in the cycle after.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 cmp32(reg_rdata_out, exp);
  endtask

  task automatic pulse_scan();
    @(posedge clock_in);
    scan_done_in <= 1'b1;
    @(posedge clock_in);
    scan_done_in <= 1'b0;
    exp_cnt++;
  endtask

  // Random status word: numbers 1 to 10 in the bank and pair nibbles, every other bit free.
  function automatic logic [31:0] mk_func();
    logic [31:0] v;
    v = $random(seed);
    for (int k = 2; k < 6; k++)
      v[k*4 +: 4] = 4'(($random(seed) & 32'h7fff_ffff) % 10 + 1);
    return v;
  endfunction

  // Expected telegram byte; spare bits of the latched status are masked off.
  function automatic logic [7:0] exp_byte(input int i, input logic [31:0] c);
    logic [31:0] a;
    logic [31:0] b;
    a = fa_lat & 32'hf8ff_fffc;
    b = fb_lat & 32'hf8ff_fffc;
    if (i == 0)
      return 8'h01;
    if (i >= 8 && i < 12)
      return c[(i-8)*8 +: 8];
    if (i >= 12 && i < 16)
      return a[(15-i)*8 +: 8];
    if (i >= 16)
      return b[(19-i)*8 +: 8];
    return 8'h00;
  endfunction

  // Waits a bounded time for the host to see byte 19, then checks the whole frame.
  task automatic check_frame(input logic [31:0] c);
    n = frame_count;
    for (int i = 0; i < 3000 && frame_count == n; i++)
      @(posedge clock_in);
    // A frame that never completes is a mismatch, not a silent skip.
    if (frame_count == n)
    begin
      bad_count++;
      $display("CHECK FAILED %0t no frame within limit", $time);
    end
    repeat (20) @(posedge clock_in);
    for (int i = 0; i < 12; i++)
      cmp8(frame[i*8 +: 8], exp_byte(i, c));
    for (int i = 12; i < 20; i++)
      cmp8(frame[i*8 +: 8], exp_byte(i, c));
    cmp32(scan_seen, c);
  endtask

  // Watchdog: far beyond the few thousand cycles the sequence needs.
  initial
  begin
    repeat (40000) @(posedge clock_in);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    seed = 66;
    {bad_count, tests_run, exp_cnt} = '0;
    {rstn_in, scan_done_in, status_load_in, reg_wr_in, reg_rd_in} = '0;
    {reg_addr_in, reg_wdata_in, fa_r, fb_r, fa_lat, fb_lat, stall_r} = '0;
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(8'h0c, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h00, 32'h0000_0001);
    rd(8'h40, 32'h0000_0000);
    // Inputs change but are never loaded, so the first frame still carries zeros.
    fa_r <= mk_func();
    fb_r <= mk_func();
    pulse_scan();
    check_frame(exp_cnt);
    for (int t = 0; t < 6; t++)
    begin
      fa_r <= mk_func();
      fb_r <= mk_func();
      stall_r <= 2'($random(seed));
      @(posedge clock_in);
      status_load_in <= 1'b1;
      @(posedge clock_in);
      status_load_in <= 1'b0;
      fa_lat = fa_r;
      fb_lat = fb_r;
      rd(8'h14, fa_lat & 32'hf8ff_fffc);
      rd(8'h18, fb_lat & 32'hf8ff_fffc);
      pulse_scan();
      n = exp_cnt;
      // A scan in mid-frame is counted but sends nothing.
      if (t == 2)
        pulse_scan();
      check_frame(n);
    end
    rd(8'h04, 32'h0000_0007);
    rd(8'h0c, exp_cnt);
    cmp32({31'h0, irq_out}, 32'h0000_0000);
    wr(8'h08, 32'h0000_0004);
    repeat (2) @(posedge clock_in);
    cmp32({31'h0, irq_out}, 32'h0000_0001);
    wr(8'h04, 32'h0000_0007);
    repeat (2) @(posedge clock_in);
    cmp32({31'h0, irq_out}, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    // A forced send repeats the count without a new scan.
    wr(8'h00, 32'h0000_0003);
    check_frame(exp_cnt);
    // With sending disabled a scan gives no frame.
    wr(8'h00, 32'h0000_0000);
    n = frame_count;
    pulse_scan();
    repeat (100) @(posedge clock_in);
    cmp32(frame_count, n);
    // Only a power-up style reset brings the scan counter back to zero.
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(8'h0c, 32'h0000_0000);
    rd(8'h00, 32'h0000_0001);
    tally_and_finish();
  end
endmodule
